// >>> rtl/gpp_defs.vh
// register indices, field masks, reset values for the port block
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH
`define GPP_ADDR_W        18
`define GPP_IDX_DATA      16'hffdb
`define GPP_IDX_DIR       16'hffeb
`define GPP_IDX_PULLUP    16'hf086
`define GPP_IDX_FUNC      16'hf088
`define GPP_BIT_MASK      8'h0c
`define GPP_BIT_LO        2
`define GPP_BIT_HI        3
`define GPP_DATA_RST      8'h00
`define GPP_DIR_RST       8'h00
`define GPP_PULLUP_RST    8'h00
`define GPP_FUNC_RST      8'h0c
`define GPP_DIR_READ      8'h00
`define GPP_SYNC_STAGES   2
`endif

// >>> rtl/gpp_port.v
// general-purpose port bits 3 and 2 with direction, pull-up and data registers
// Operation
// - a direction bit of 1 makes its pin an output and 0 makes it an input.
// - direction and data only act on a pin while it is in general input/output function.
// - the direction register is write-only and reads return an undefined value.
// - with direction 0, a pull-up bit of 1 turns the pin pull-up on and 0 turns it off; the code also requires general input/output function.
// - a data read returns the latch when direction is 1 and the pin level when 0.
`timescale 1ns/1ps
`include "gpp_defs.vh"
module gpp_port (
  input  wire                    clk,        // bus clock, 125 MHz
  input  wire                    rst,        // async reset, high
  input  wire                    psel,       // apb select
  input  wire                    penable,    // apb enable
  input  wire                    pwrite,     // apb direction
  input  wire [`GPP_ADDR_W-1:0]  paddr,      // apb byte address
  input  wire [31:0]             pwdata,     // apb write data
  output reg  [31:0]             prdata,     // apb read data
  output reg                     pready,     // apb ready
  output reg                     pslverr,    // apb error, unmapped address
  input  wire [7:0]              pin_in,     // pin levels, asynchronous
  output reg  [7:0]              pin_out,    // pin output values
  output reg  [7:0]              pin_oe,     // pin output enables
  output reg  [7:0]              pullup_en   // pin pull-up enables
);
  // byte addresses: register index times four
  localparam [`GPP_ADDR_W-1:0] A_DATA   = {`GPP_IDX_DATA, 2'b00};
  localparam [`GPP_ADDR_W-1:0] A_DIR    = {`GPP_IDX_DIR, 2'b00};
  localparam [`GPP_ADDR_W-1:0] A_PULLUP = {`GPP_IDX_PULLUP, 2'b00};
  localparam [`GPP_ADDR_W-1:0] A_FUNC   = {`GPP_IDX_FUNC, 2'b00};

  // implemented bits
  localparam [7:0] IMPL_MASK = `GPP_BIT_MASK;

  // register select codes, one-hot except SEL_NONE, which is zero
  localparam [3:0] SEL_NONE   = 4'h0;
  localparam [3:0] SEL_DATA   = 4'h1;
  localparam [3:0] SEL_DIR    = 4'h2;
  localparam [3:0] SEL_PULLUP = 4'h4;
  localparam [3:0] SEL_FUNC   = 4'h8;

  // apb slave states, one-hot
  localparam [1:0] ST_WAIT   = 2'h1;
  localparam [1:0] ST_ANSWER = 2'h2;

  // stored settings, only bits 3 and 2 ever set
  reg  [7:0]  port_data_latch_q;
  reg  [7:0]  port_direction_control_q;
  reg  [7:0]  port_pullup_control_q;
  reg  [7:0]  gio_select_q;
  reg  [1:0]  state_q;

  // next values
  reg  [1:0]  state_d;
  reg         pready_d;
  reg         pslverr_d;
  reg  [31:0] prdata_d;
  reg  [31:0] rdata_d;
  reg         hit_d;
  wire [7:0]  pin_oe_d;
  wire [7:0]  pin_out_d;
  wire [7:0]  pullup_en_d;
  wire [7:0]  read_port_d;

  // decode and strobes
  wire [7:0]  pin_sync;
  wire        access;
  wire        wr_acc;
  wire [3:0]  rd_sel;
  wire [3:0]  wr_sel;

  // address to register select, shared by read mux and write strobes
  function [3:0] reg_select;
    input [`GPP_ADDR_W-1:0] addr;
    begin
      case (addr)
        A_DATA:   reg_select = SEL_DATA;
        A_DIR:    reg_select = SEL_DIR;
        A_PULLUP: reg_select = SEL_PULLUP;
        A_FUNC:   reg_select = SEL_FUNC;
        default:  reg_select = SEL_NONE;
      endcase
    end
  endfunction

  // pins are asynchronous, two flops before any logic
  gpp_sync #(
    .W (8)
  ) gpp_sync_inst (
    .clk (clk),
    .rst (rst),
    .d   (pin_in),
    .q   (pin_sync)
  );

  // first access cycle only; the answer cycle must not repeat a write
  assign access = psel & penable & (state_q == ST_WAIT);
  assign wr_acc = access & pwrite;
  assign rd_sel = reg_select(paddr);
  assign wr_sel = wr_acc ? reg_select(paddr) : SEL_NONE;

  // per-bit pin control; a pin out of general i/o ignores direction and data
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bit
      if ((b >= `GPP_BIT_LO) && (b <= `GPP_BIT_HI)) begin : g_impl
        assign pin_oe_d[b]    = port_direction_control_q[b] & gio_select_q[b];
        assign pin_out_d[b]   = port_direction_control_q[b] & gio_select_q[b] & port_data_latch_q[b];
        assign pullup_en_d[b] = ~port_direction_control_q[b] & gio_select_q[b] & port_pullup_control_q[b];
        assign read_port_d[b] = port_direction_control_q[b] ? port_data_latch_q[b] : pin_sync[b];
      end else begin : g_none
        assign pin_oe_d[b]    = 1'b0;
        assign pin_out_d[b]   = 1'b0;
        assign pullup_en_d[b] = 1'b0;
        assign read_port_d[b] = 1'b0;
      end
    end
  endgenerate

  // read mux; direction reads back a fixed value
  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (rd_sel)
      SEL_DATA:   rdata_d[7:0] = read_port_d;
      SEL_DIR:    rdata_d[7:0] = `GPP_DIR_READ;
      SEL_PULLUP: rdata_d[7:0] = port_pullup_control_q & IMPL_MASK;
      SEL_FUNC:   rdata_d[7:0] = gio_select_q & IMPL_MASK;
      default:    hit_d = 1'b0;
    endcase
  end

  // apb slave: one wait state, answer in second access cycle
  always @* begin
    state_d   = state_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    case (state_q)
      ST_WAIT: begin
        if (psel & penable) begin
          state_d   = ST_ANSWER;
          pready_d  = 1'b1;
          // unmapped: error flagged, read data stays zero
          pslverr_d = ~hit_d;
          if (~pwrite)
            prdata_d = rdata_d;
        end
      end
      ST_ANSWER: begin
        // ready stands one cycle
        state_d = ST_WAIT;
      end
      default: begin
        state_d = ST_WAIT;
      end
    endcase
  end

  // answer registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_WAIT;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
    end
  end

  // data latch, only implemented bits stored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port_data_latch_q <= `GPP_DATA_RST;
    end else if (wr_sel == SEL_DATA) begin
      port_data_latch_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // direction, write-only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port_direction_control_q <= `GPP_DIR_RST;
    end else if (wr_sel == SEL_DIR) begin
      port_direction_control_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // pull-up control
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port_pullup_control_q <= `GPP_PULLUP_RST;
    end else if (wr_sel == SEL_PULLUP) begin
      port_pullup_control_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // general i/o select, set bit hands the pin to this block
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gio_select_q <= `GPP_FUNC_RST;
    end else if (wr_sel == SEL_FUNC) begin
      gio_select_q <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // pin drive, one cycle after the settings
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_oe    <= 8'h00;
      pin_out   <= 8'h00;
      pullup_en <= 8'h00;
    end else begin
      pin_oe    <= pin_oe_d;
      pin_out   <= pin_out_d;
      pullup_en <= pullup_en_d;
    end
  end
endmodule // gpp_port

// >>> rtl/gpp_sync.v
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module gpp_sync #(
  parameter W = 8
) (
  input  wire         clk,   // bus clock
  input  wire         rst,   // async reset, high
  input  wire [W-1:0] d,     // asynchronous level
  output wire [W-1:0] q      // synchronised level
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // gpp_sync

// >>> testbench/gpp_pins.sv
// board side of the pins
`timescale 1ns/1ps
module gpp_pins (
  input  wire logic [7:0] pin_out,   // design output values
  input  wire logic [7:0] pin_oe,    // design output enables
  input  wire logic [7:0] pullup_en, // design pull-up enables
  input  wire logic [7:0] lvl,       // board drive level
  input  wire logic [7:0] drv,       // board drives the line
  output wire logic [7:0] pin_in     // level seen on the pin
);
  // a floating line reads the inverse of the last board level
  assign pin_in = pin_oe & pin_out | ~pin_oe & (drv & lvl | ~drv & (pullup_en | ~lvl));
endmodule // gpp_pins

// >>> testbench/gpp_port_sva.sv
// port block checker
`timescale 1ns/1ps
module gpp_port_sva (
  input wire logic        clk,       // bus clock
  input wire logic        rst,       // async reset, high
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb enable
  input wire logic        pwrite,    // apb direction
  input wire logic        pready,    // apb ready
  input wire logic        pslverr,   // apb error
  input wire logic [17:0] paddr,     // apb byte address
  input wire logic [31:0] prdata,    // apb read data
  input wire logic [7:0]  pin_out,   // pin output values
  input wire logic [7:0]  pin_oe,    // pin output enables
  input wire logic [7:0]  pullup_en  // pin pull-up enables
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_first_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  ready_next_a: assert property (s_first_access |=> s_answer) else $error("answer");
  err_ready_a: assert property (pslverr |-> pready) else $error("err");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("rdata");
  oe_cause_a: assert property (!$stable(pin_oe) |-> $past(psel && penable && pwrite && !pready, 2)) else $error("oe");
  stray_pin_a: assert property (((pin_oe | pin_out | pullup_en) & 8'hf3) == 8'h0) else $error("pin");
  dir_ok_a: assert property (psel && pready && paddr == 18'h3ffac |-> !pslverr) else $error("dir");
  pull_in_a: assert property ((pullup_en & pin_oe) == 8'h0) else $error("pu");
  out_en_a: assert property ((pin_out & ~pin_oe) == 8'h0) else $error("out");
  ready_one_a: assert property (pready |=> !pready) else $error("rdy");
endmodule // gpp_port_sva

// >>> testbench/gpp_port_test.sv
// port block bench
`timescale 1ns/1ps
module gpp_port_test;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pe;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] pin_in, pin_out, pin_oe, pullup_en, rd, lvl = 8'hff, drv = 0;
  int fails = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  gpp_port gpp_port_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en));
  gpp_pins gpp_pins_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .lvl(lvl), .drv(drv),
    .pin_in(pin_in));
  task test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 500) begin fails++; test_done; end
  task chk(string n, logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end
  endtask
  task bus(logic w, logic [15:0] a, logic [7:0] d);
    @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 26'h0, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {rd, pe} = {prdata[7:0], pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task t1;
    chk("rst pins", 8'h00, pin_oe | pin_out | pullup_en);
    bus(1, 16'hffdb, 8'h04);
    bus(1, 16'hffeb, 8'h0c);
    @(negedge clk) chk("oe", 8'h0c, pin_oe);
    chk("out", 8'h04, pin_out);
    bus(0, 16'hffdb, 8'h00);
    chk("rd", 8'h04, rd);
    $display("t1 end");
  endtask
  task t2;
    bus(1, 16'hffeb, 8'h00);
    bus(1, 16'hf086, 8'h0c);
    bus(0, 16'hf086, 8'h00);
    chk("pu rd", 8'h0c, rd);
    bus(0, 16'hffdb, 8'h00);
    chk("pu", 8'h0c, pullup_en);
    chk("hi", 8'h0c, rd);
    bus(1, 16'hf086, 8'h00);
    bus(0, 16'hffdb, 8'h00);
    chk("pu off", 8'h00, pullup_en);
    chk("float", 8'h00, rd);
    {drv, lvl} <= 16'h0c04;
    bus(0, 16'hffdb, 8'h00);
    chk("lo", 8'h04, rd);
    $display("t2 end");
  endtask
  task t3;
    bus(1, 16'hffeb, 8'h0c);
    bus(1, 16'hf088, 8'h00);
    bus(0, 16'hffeb, 8'h00);
    chk("gio", 8'h00, pin_oe);
    chk("gio out", 8'h00, pin_out);
    chk("dir", 8'h00, {7'h0, pe});
    bus(0, 16'h0001, 8'h00);
    chk("err", 8'h01, {7'h0, pe});
    chk("err rd", 8'h00, rd);
    $display("t3 end");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t1;
    t2;
    t3;
    test_done;
  end
endmodule // gpp_port_test
bind gpp_port gpp_port_sva gpp_port_sva_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .pullup_en(pullup_en));
